// ===== include/scio_pkg.sv
/*
 * Shared constants, types and helpers for the strobe capture I/O datapath.
 * Assumes a single 40 MHz core clock; every slower rate is an enable pulse.
 */
package scio_pkg;

    localparam int DQ_W    = 8;
    localparam int SET_W   = 6;
    localparam int OFS_W   = 7;
    localparam int CFG_W   = 25;
    localparam int IDX_W   = 8;
    localparam int HIST_D  = 256;
    localparam int SYNC_W  = 23;

    localparam logic [3:0]       CFG_ADDR  = 4'h0;
    localparam logic [3:0]       STAT_ADDR = 4'h4;
    localparam logic [CFG_W-1:0] CFG_RESET = 25'h0000000;

    // Chain timing in core cycles: intrinsic per element, then per step.
    localparam logic [9:0] INTR_CYC = 10'h001;
    localparam logic [9:0] STEP_CYC = 10'h001;
    localparam logic [9:0] HIST_LEN = 10'h100;

    localparam logic [SET_W-1:0] SET_MAX_FULL = 6'h3f;
    localparam logic [SET_W-1:0] SET_MAX_RED  = 6'h1f;

    // Update period stands for the reference clock; resync for the PLL.
    localparam logic [7:0] UPD_DIV    = 8'h1f;
    localparam logic [7:0] RESYNC_DIV = 8'h01;

    localparam logic [1:0] PH_DATA_RISE = 2'h0;
    localparam logic [1:0] PH_STRB_RISE = 2'h1;
    localparam logic [1:0] PH_DATA_FALL = 2'h2;
    localparam logic [1:0] PH_STRB_FALL = 2'h3;

    typedef enum logic [1:0] {SRC_PSU_A, SRC_PSU_B, SRC_CORE, SRC_SPARE}
        scio_src_type;
    typedef enum logic [1:0] {CAP_GATED, CAP_UNGATED, CAP_GLOBAL, CAP_SPARE}
        scio_capsel_type;
    typedef enum logic [1:0] {OUT_COMB, OUT_SDR, OUT_DDR, OUT_SPARE}
        scio_omode_type;

    typedef struct packed {
        logic [OFS_W-1:0] offset;
        logic             dyn_cnt;
        logic             upd_user;
        logic             oe_reg;
        scio_omode_type   out_mode;
        logic             resync_byp;
        logic             cap_byp;
        scio_capsel_type  cap_sel;
        logic             comp_clk;
        logic             invert;
        logic             bypass;
        logic [1:0]       elem_cnt;
        logic             ofs_en;
        logic             reduced;
        scio_src_type     src;
    } scio_cfg_type;

    typedef struct packed {
        logic [DQ_W-1:0] hi;
        logic [DQ_W-1:0] lo;
    } scio_pair_type;

    function automatic logic [SET_W-1:0] gray2bin(input logic [SET_W-1:0] g);
        logic [SET_W-1:0] b;
        b[SET_W-1] = g[SET_W-1];
        for (int i = SET_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage

// ===== rtl/scio_sync2.sv
/*
 * Two-flop synchroniser for a bundle of pin-level inputs.
 * Assumes the inputs are levels or Gray-coded words from outside the clock.
 */
`timescale 1ns/1ps
module scio_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ===== rtl/scio_strobe_unit.sv
/*
 * One strobe conditioning unit: update-gated setting registers, a
 * four-element delay chain modelled as a strobe history, and postamble gating.
 * Assumes a synchronised strobe and a one-cycle update pulse on clk.
 */
`timescale 1ns/1ps
module scio_strobe_unit
    import scio_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             strobe,
    input  wire logic             upd,
    input  wire logic [SET_W-1:0] setting,
    input  wire logic [OFS_W-1:0] offset,
    input  wire logic             ofs_en,
    input  wire logic             reduced,
    input  wire logic [1:0]       cnt,
    input  wire logic             bypass,
    input  wire logic             win_en,
    output logic                  delayed,
    output logic                  gated,
    output logic                  armed,
    output logic      [SET_W-1:0] applied
);
    logic [OFS_W-1:0]  ofs_r;
    logic              ofs_en_r;
    logic              reduced_r;
    logic [1:0]        cnt_r;
    logic [HIST_D-1:0] hist;
    logic              dly_prev;
    logic signed [8:0] e1_raw;
    logic [SET_W-1:0]  maxv;
    logic [SET_W-1:0]  e1;
    logic [9:0]        tot;
    logic [IDX_W-1:0]  idx;

    // All elements see a new setting in the same cycle, never a mix.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            applied   <= '0;
            ofs_r     <= '0;
            ofs_en_r  <= 1'b0;
            reduced_r <= 1'b0;
            cnt_r     <= '0;
        end else if (upd) begin
            applied   <= setting;
            ofs_r     <= offset;
            ofs_en_r  <= ofs_en;
            reduced_r <= reduced;
            cnt_r     <= cnt;
        end
    end

    always_comb begin
        e1_raw = $signed({3'b000, applied});
        if (ofs_en_r) begin
            e1_raw = e1_raw + $signed({{2{ofs_r[OFS_W-1]}}, ofs_r});
        end
        maxv = reduced_r ? SET_MAX_RED : SET_MAX_FULL;
        if (e1_raw < 9'sh000) begin
            e1 = '0;
        end else if (e1_raw > $signed({3'b000, maxv})) begin
            e1 = maxv;
        end else begin
            e1 = e1_raw[SET_W-1:0];
        end
        // Intrinsic delay per element plus steps times step value.
        tot = 10'(({8'h00, cnt_r} + 10'h001) * INTR_CYC)
            + 10'(10'({4'h0, e1} + 10'(cnt_r) * {4'h0, applied}) * STEP_CYC);
        idx = (tot > HIST_LEN) ? 8'hff : IDX_W'(tot - 10'h001);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist <= '0;
        end else begin
            hist <= {hist[HIST_D-2:0], strobe};
        end
    end

    assign delayed = bypass ? strobe : hist[idx];

    // The window arms on a delayed-strobe fall and drops at once on release.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dly_prev <= 1'b0;
            armed    <= 1'b0;
        end else begin
            dly_prev <= delayed;
            if (!win_en) begin
                armed <= 1'b0;
            end else if (dly_prev && !delayed) begin
                armed <= 1'b1;
            end
        end
    end

    assign gated = delayed & armed & win_en;

    property p_hold_setting;
        @(posedge clk) disable iff (!rst_n)
        !upd |=> $stable(applied);
    endproperty
    a_hold_setting: assert property (p_hold_setting)
        else $error("Setting changed without update pulse.");

    property p_load_setting;
        @(posedge clk) disable iff (!rst_n)
        upd |=> applied == $past(setting);
    endproperty
    a_load_setting: assert property (p_load_setting)
        else $error("Update pulse did not load the setting.");

    property p_gate_closed;
        @(posedge clk) disable iff (!rst_n)
        !win_en |-> !gated ##1 (!armed || win_en);
    endproperty
    a_gate_closed: assert property (p_gate_closed)
        else $error("Gated strobe passed outside the read window.");

    property p_bypass_zero;
        @(posedge clk) disable iff (!rst_n)
        bypass |-> delayed == strobe;
    endproperty
    a_bypass_zero: assert property (p_bypass_zero)
        else $error("Bypassed chain added delay.");

    property p_arm_half;
        @(posedge clk) disable iff (!rst_n)
        win_en && !armed && dly_prev && !delayed |=> armed || !$past(win_en);
    endproperty
    a_arm_half: assert property (p_arm_half)
        else $error("Window did not arm on strobe fall.");
endmodule

// ===== rtl/scio_top.sv
/*
 * Strobe capture and I/O register datapath of one strobe group.
 * Assumes all logic on CORE_CLK; strobe, data, global clock and phase-shift
 * unit words arrive from outside and are synchronised first.
 */
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

// Functional notes
// - Each strobe pin has its own conditioning unit
// - Four elements; first may add phase offset
// - Setting from either phase unit or core
// - One to four elements, static or dynamic
// - Delay is intrinsic plus steps times step
// - Chain bypass gives zero shift
// - Settings load only on update enable
// - Update from reference divider or user
// - Postamble gating grounds strobe after read
// - AND gate; arms late, drops at once
// - Core drives read window around bursts
// - Capture then resync, each bypassable
// - Rise, fall and align capture registers
// - Shared or complementary capture clocks
// - Resync registers on PLL resync clock
// - Capture clock: gated, ungated or global
// - Echo mode falls from complement unit
// - Invert strobe for SDRAM, not SRAM
// - Output combinational, SDR or DDR; combinational mode still loads WR_DATA_HI into DQ_OUT each cycle
// - Output enable combinational or registered; combinational mode still loads ~WR_OE into the OE flops each cycle
// - Strobe write clock 90 degrees after data
// - Reduced range forces setting MSB zero
// - Phase unit settings are Gray coded
module scio_top
    import scio_pkg::*;
(
    input  wire logic             CORE_CLK,
    input  wire logic             RST_N,
    input  wire logic [3:0]       ADDR,
    input  wire logic [31:0]      WDATA,
    input  wire logic             WR,
    input  wire logic             RD,
    output logic      [31:0]      REG_RDATA,
    input  wire logic             STROBE_PIN,
    input  wire logic             STROBE_COMP_PIN,
    input  wire logic             GCLK_PIN,
    input  wire logic [DQ_W-1:0]  DQ_IN,
    output logic      [DQ_W-1:0]  DQ_OUT,
    output logic                  DQ_OE_N,
    output logic                  STROBE_OUT,
    output logic                  STROBE_OE_N,
    input  wire logic [SET_W-1:0] PSU_A_DELAY,
    input  wire logic [SET_W-1:0] PSU_B_DELAY,
    input  wire logic [SET_W-1:0] CORE_DELAY,
    input  wire logic             USER_UPDATE,
    input  wire logic [1:0]       ELEM_COUNT,
    input  wire logic             READ_WINDOW,
    input  wire logic [DQ_W-1:0]  WR_DATA_HI,
    input  wire logic [DQ_W-1:0]  WR_DATA_LO,
    input  wire logic             WR_OE,
    output logic      [DQ_W-1:0]  RD_DATA_HI,
    output logic      [DQ_W-1:0]  RD_DATA_LO,
    output logic                  UPDATE_OUT
);
    scio_cfg_type     cfg;
    logic [SYNC_W-1:0] sync_q;
    logic             strb_s;
    logic             strb_c_s;
    logic             gclk_s;
    logic [DQ_W-1:0]  dq_s;
    logic [SET_W-1:0] psu_a_s;
    logic [SET_W-1:0] psu_b_s;
    logic [SET_W-1:0] next_set;
    logic [SET_W-1:0] sel_set;
    logic [1:0]       cnt_sel;
    logic [7:0]       upd_cnt;
    logic             ref_tick;
    logic             upd_q;
    logic             t_dly;
    logic             t_gated;
    logic             t_armed;
    logic [SET_W-1:0] t_applied;
    logic             c_dly;
    logic             c_gated;
    logic             cap_t;
    logic             cap_c;
    logic             prev_t;
    logic             prev_c;
    logic             rise_t;
    logic             fall_ev;
    logic [DQ_W-1:0]  hi_cap;
    logic [DQ_W-1:0]  lo_cap;
    logic [DQ_W-1:0]  al_lo;
    scio_pair_type    cap;
    logic [7:0]       rs_cnt;
    logic             rs_tick;
    logic [1:0]       wr_ph;

    // Register port: one configuration word and one status word.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg <= CFG_RESET;
        end else if (WR && ADDR == CFG_ADDR) begin
            cfg <= WDATA[CFG_W-1:0];
        end
    end

    // Read data exist only in the cycle after the strobe; otherwise zero.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            REG_RDATA <= '0;
        end else if (RD && ADDR == CFG_ADDR) begin
            REG_RDATA <= {7'h00, cfg};
        end else if (RD && ADDR == STAT_ADDR) begin
            REG_RDATA <= {24'h000000, 1'b0, t_armed, t_applied};
        end else begin
            REG_RDATA <= '0;
        end
    end

    scio_sync2 #(
        .W (SYNC_W)
    ) u_sync (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .d     ({STROBE_PIN, STROBE_COMP_PIN, GCLK_PIN, DQ_IN,
                 PSU_A_DELAY, PSU_B_DELAY}),
        .q     (sync_q)
    );

    assign {strb_s, strb_c_s, gclk_s, dq_s, psu_a_s, psu_b_s} = sync_q;

    // Gray words survive the two-flop crossing one bit step at a time.
    always_comb begin
        case (cfg.src)
            SRC_PSU_A: next_set = gray2bin(psu_a_s);
            SRC_PSU_B: next_set = gray2bin(psu_b_s);
            default:   next_set = gray2bin(CORE_DELAY);
        endcase
        if (cfg.reduced) begin
            next_set[SET_W-1] = 1'b0;
        end
        cnt_sel = cfg.dyn_cnt ? ELEM_COUNT : cfg.elem_cnt;
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sel_set <= '0;
        end else begin
            sel_set <= next_set;
        end
    end

    // The reference divider stands in for the input reference clock.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            upd_cnt <= '0;
        end else if (ref_tick) begin
            upd_cnt <= '0;
        end else begin
            upd_cnt <= upd_cnt + 8'h01;
        end
    end

    assign ref_tick = (upd_cnt == UPD_DIV);

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            upd_q <= 1'b0;
        end else begin
            upd_q <= cfg.upd_user ? USER_UPDATE : ref_tick;
        end
    end

    assign UPDATE_OUT = upd_q;

    scio_strobe_unit u_true (
        .clk     (CORE_CLK),
        .rst_n   (RST_N),
        .strobe  (strb_s),
        .upd     (upd_q),
        .setting (sel_set),
        .offset  (cfg.offset),
        .ofs_en  (cfg.ofs_en),
        .reduced (cfg.reduced),
        .cnt     (cnt_sel),
        .bypass  (cfg.bypass),
        .win_en  (READ_WINDOW),
        .delayed (t_dly),
        .gated   (t_gated),
        .armed   (t_armed),
        .applied (t_applied)
    );

    scio_strobe_unit u_comp (
        .clk     (CORE_CLK),
        .rst_n   (RST_N),
        .strobe  (strb_c_s),
        .upd     (upd_q),
        .setting (sel_set),
        .offset  (cfg.offset),
        .ofs_en  (cfg.ofs_en),
        .reduced (cfg.reduced),
        .cnt     (cnt_sel),
        .bypass  (cfg.bypass),
        .win_en  (READ_WINDOW),
        .delayed (c_dly),
        .gated   (c_gated),
        .armed   (),
        .applied ()
    );

    always_comb begin
        case (cfg.cap_sel)
            CAP_GATED: begin
                cap_t = t_gated;
                cap_c = c_gated;
            end
            CAP_UNGATED: begin
                cap_t = t_dly;
                cap_c = c_dly;
            end
            default: begin
                cap_t = gclk_s;
                cap_c = ~gclk_s;
            end
        endcase
        cap_t = cap_t ^ cfg.invert;
        cap_c = cap_c ^ cfg.invert;
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            prev_t <= 1'b0;
            prev_c <= 1'b0;
        end else begin
            prev_t <= cap_t;
            prev_c <= cap_c;
        end
    end

    assign rise_t  = cap_t & ~prev_t;
    assign fall_ev = cfg.comp_clk ? (cap_c & ~prev_c)
                                  : (~cap_t & prev_t);

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            hi_cap <= '0;
            al_lo  <= '0;
        end else if (rise_t) begin
            hi_cap <= dq_s;
            al_lo  <= lo_cap;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            lo_cap <= '0;
        end else if (fall_ev) begin
            lo_cap <= dq_s;
        end
    end

    always_comb begin
        if (cfg.cap_byp) begin
            cap.hi = dq_s;
            cap.lo = dq_s;
        end else begin
            cap.hi = hi_cap;
            cap.lo = al_lo;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rs_cnt <= '0;
        end else if (rs_tick) begin
            rs_cnt <= '0;
        end else begin
            rs_cnt <= rs_cnt + 8'h01;
        end
    end

    assign rs_tick = (rs_cnt == RESYNC_DIV);

    // Bypassing resync still leaves one flop so outputs stay registered.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            RD_DATA_HI <= '0;
            RD_DATA_LO <= '0;
        end else if (rs_tick || cfg.resync_byp) begin
            RD_DATA_HI <= cap.hi;
            RD_DATA_LO <= cap.lo;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_ph <= PH_DATA_RISE;
        end else begin
            wr_ph <= wr_ph + 2'h1;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            STROBE_OUT <= 1'b0;
        end else begin
            STROBE_OUT <= (wr_ph == PH_STRB_RISE)
                       || (wr_ph == PH_DATA_FALL);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            DQ_OUT <= '0;
        end else begin
            case (cfg.out_mode)
                OUT_COMB: DQ_OUT <= WR_DATA_HI;
                OUT_SDR: begin
                    if (wr_ph == PH_DATA_RISE) begin
                        DQ_OUT <= WR_DATA_HI;
                    end
                end
                OUT_DDR: begin
                    if (wr_ph == PH_DATA_RISE) begin
                        DQ_OUT <= WR_DATA_HI;
                    end else if (wr_ph == PH_DATA_FALL) begin
                        DQ_OUT <= WR_DATA_LO;
                    end
                end
                default: DQ_OUT <= WR_DATA_HI;
            endcase
        end
    end

    // Pins float after reset until core requests drive.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            DQ_OE_N     <= 1'b1;
            STROBE_OE_N <= 1'b1;
        end else if (!cfg.oe_reg || wr_ph == PH_DATA_RISE) begin
            DQ_OE_N     <= ~WR_OE;
            STROBE_OE_N <= ~WR_OE;
        end
    end

    property p_strobe_quarter;
        @(posedge CORE_CLK) disable iff (!RST_N)
        wr_ph == PH_DATA_RISE |=> !STROBE_OUT ##1 STROBE_OUT [*2]
                                 ##1 !STROBE_OUT;
    endproperty
    a_strobe_quarter: assert property (p_strobe_quarter)
        else $error("Strobe write clock not a quarter period late.");

    property p_ddr_low;
        @(posedge CORE_CLK) disable iff (!RST_N)
        cfg.out_mode == OUT_DDR && wr_ph == PH_DATA_FALL
            |=> DQ_OUT == $past(WR_DATA_LO);
    endproperty
    a_ddr_low: assert property (p_ddr_low)
        else $error("Second half of DDR output is wrong.");

    property p_oe_comb;
        @(posedge CORE_CLK) disable iff (!RST_N)
        !cfg.oe_reg |=> DQ_OE_N == !$past(WR_OE);
    endproperty
    a_oe_comb: assert property (p_oe_comb)
        else $error("Combinational output enable did not follow.");

    property p_resync_load;
        @(posedge CORE_CLK) disable iff (!RST_N)
        rs_tick |=> RD_DATA_HI == $past(cap.hi);
    endproperty
    a_resync_load: assert property (p_resync_load)
        else $error("Resync register missed captured data.");

    property p_rise_capture;
        @(posedge CORE_CLK) disable iff (!RST_N)
        rise_t |=> hi_cap == $past(dq_s) && al_lo == $past(lo_cap);
    endproperty
    a_rise_capture: assert property (p_rise_capture)
        else $error("Rising capture or alignment wrong.");

    property p_reduced_msb;
        @(posedge CORE_CLK) disable iff (!RST_N)
        cfg.reduced ##1 cfg.reduced |-> !sel_set[SET_W-1];
    endproperty
    a_reduced_msb: assert property (p_reduced_msb)
        else $error("Setting MSB set in reduced range.");
endmodule

// ===== dv/scio_mem_model.sv
/*
 * Memory-side model that answers reads with a strobe pair and data.
 * Assumes the bench calls burst and that data is centre-aligned to strobe.
 */
`timescale 1ns/1ps
module scio_mem_model
    import scio_pkg::*;
(
    input  wire logic            clk,
    output logic                 strobe,
    output logic                 strobe_n,
    output logic      [DQ_W-1:0] dq
);
    initial begin
        strobe = 1'b0;
        strobe_n = 1'b1;
        dq = 8'h00;
    end
    // Released data shows the inverse of its last value, never a held copy.
    task automatic burst(input logic [DQ_W-1:0] a, input logic [DQ_W-1:0] b,
                         input int n, input int half);
        for (int i = 0; i < 2 * n; i++) begin
            dq <= i[0] ? b : a;
            repeat (half) @(posedge clk);
            strobe <= !i[0];
            strobe_n <= i[0];
            repeat (half) @(posedge clk);
        end
        dq <= ~b;
    endtask
endmodule

// ===== dv/scio_top_tb.sv
/*
 * Self-checking bench for scio_top: updates, outputs and capture.
 * Assumes the memory model drives the strobe and data pins.
 */
`timescale 1ns/1ps
module scio_top_tb
    import scio_pkg::*;
;
    logic             clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic             uupd = 1'b0, rwin = 1'b0, woe = 1'b0;
    logic [3:0]       addr = 4'h0;
    logic [31:0]      wdata = 32'h0, rdata, v;
    logic [SET_W-1:0] dla = 6'h00, dlb = 6'h00, dlc = 6'h00;
    logic [DQ_W-1:0]  whi = 8'h00, wlo = 8'h00, dqo, rhi, rlo, mdq;
    logic             ms, msn, dqoe_n, soe_n, sout, updo;
    int               miscompares = 0, checks = 0, n;

    always #12.5 clk = ~clk;

    scio_top i_dut (.CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .REG_RDATA(rdata), .STROBE_PIN(ms),
        .STROBE_COMP_PIN(msn), .GCLK_PIN(ms), .DQ_IN(mdq), .DQ_OUT(dqo),
        .DQ_OE_N(dqoe_n), .STROBE_OUT(sout), .STROBE_OE_N(soe_n),
        .PSU_A_DELAY(dla), .PSU_B_DELAY(dlb), .CORE_DELAY(dlc),
        .USER_UPDATE(uupd), .ELEM_COUNT(2'h0), .READ_WINDOW(rwin),
        .WR_DATA_HI(whi), .WR_DATA_LO(wlo), .WR_OE(woe), .RD_DATA_HI(rhi),
        .RD_DATA_LO(rlo), .UPDATE_OUT(updo));
    scio_mem_model i_mem (.clk(clk), .strobe(ms), .strobe_n(msn), .dq(mdq));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask
    // Bounded wait, so a stuck output ends the run instead of hanging it.
    task automatic await(ref logic s, input logic val);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (s !== val && n < 200);
        if (s !== val) begin
            miscompares++;
            summarize();
        end
    endtask
    task automatic settle();
        await(updo, 1'b1);
        await(updo, 1'b1);
        repeat (2) @(posedge clk);
        rreg(4'h4);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        chk({28'h0, dqoe_n, soe_n, updo, sout}, 32'hc);
        rst_n <= 1'b1;
        rreg(4'h8);
        chk(v, 32'h0);
        for (int s = 0; s < 3; s++) begin
            @(posedge clk);
            dla <= 6'(s == 0);
            dlb <= 6'(s == 1);
            dlc <= 6'(s == 2);
            wreg(4'h0, 32'h40 | 32'(s));
            settle();
            chk(v & 32'h3f, 32'h1);
        end
        @(posedge clk);
        dlc <= 6'h00;
        repeat (3) @(posedge clk);
        rreg(4'h4);
        chk(v & 32'h3f, 32'h1);
        await(updo, 1'b1);
        await(updo, 1'b1);
        chk(32'(n), 32'd32);
        repeat (2) @(posedge clk);
        rreg(4'h4);
        chk(v & 32'h3f, 32'h0);
        @(posedge clk);
        dlc <= 6'h01;
        wreg(4'h0, 32'h10042);
        repeat (40) @(posedge clk);
        rreg(4'h4);
        chk(v & 32'h3f, 32'h0);
        @(posedge clk);
        uupd <= 1'b1;
        @(posedge clk);
        uupd <= 1'b0;
        await(updo, 1'b1);
        chk(32'(n < 3), 32'h1);
        repeat (2) @(posedge clk);
        rreg(4'h4);
        chk(v & 32'h3f, 32'h1);
        @(posedge clk);
        woe <= 1'b1;
        whi <= 8'ha5;
        wlo <= 8'h3c;
        for (int m = 1; m < 3; m++) begin
            wreg(4'h0, 32'(m) << 13);
            await(sout, 1'b0);
            await(sout, 1'b1);
            chk(32'(dqo), 32'ha5);
            @(negedge clk);
            chk(32'({sout, dqo}), m == 2 ? 32'h13c : 32'h1a5);
            @(negedge clk);
            chk(32'({dqoe_n, soe_n, sout}), 32'h0);
        end
        wreg(4'h0, 32'h240);
        i_mem.burst(8'h11, 8'h22, 4, 4);
        repeat (8) @(posedge clk);
        chk(32'({rhi, rlo}), 32'h1122);
        // The global line carries the memory strobe, so capture matches.
        wreg(4'h0, 32'h440);
        i_mem.burst(8'h99, 8'haa, 4, 4);
        repeat (8) @(posedge clk);
        chk(32'({rhi, rlo}), 32'h99aa);
        wreg(4'h0, 32'h340);
        i_mem.burst(8'hbb, 8'hcc, 4, 4);
        repeat (8) @(posedge clk);
        chk(32'({rhi, rlo}), 32'hbbcc);
        wreg(4'h0, 32'h2c0);
        i_mem.burst(8'h33, 8'h44, 4, 4);
        repeat (8) @(posedge clk);
        chk(32'({rhi, rlo}), 32'h4433);
        wreg(4'h0, 32'h40);
        i_mem.burst(8'h55, 8'h66, 4, 2);
        repeat (8) @(posedge clk);
        chk(32'({rhi, rlo}), 32'h4433);
        @(posedge clk);
        rwin <= 1'b1;
        i_mem.burst(8'h77, 8'h88, 4, 2);
        repeat (8) @(posedge clk);
        chk(32'({rhi, rlo}), 32'h7788);
        rreg(4'h4);
        chk(v & 32'h40, 32'h40);
        @(posedge clk);
        rwin <= 1'b0;
        rreg(4'h4);
        chk(v & 32'h40, 32'h0);
        summarize();
    end
endmodule
